// *** rtl/conv_ctrl_pkg.sv ***
// Package of register offsets, field positions, reset values and timing counts.
package conv_ctrl_pkg;

  // ****************************************************************
  // Register offsets (byte addresses).
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Control word of our own layout.
  localparam logic [7:0] OFF_CONFIG = 8'h04; // Converter configuration.
  localparam logic [7:0] OFF_STATUS = 8'h08; // Event status, clear on read.
  localparam logic [7:0] OFF_MASK   = 8'h0C; // Event mask.
  localparam logic [7:0] OFF_RESULT = 8'h14; // Conversion result, read only.
  localparam logic [7:0] OFF_UPPER  = 8'h24; // Upper window limit.
  localparam logic [7:0] OFF_LOWER  = 8'h28; // Lower window limit.

  // ****************************************************************
  // Control word fields.
  // ****************************************************************
  localparam int CTL_ANALOG_ON = 0;
  localparam int CTL_CAL_START = 1;
  localparam int CTL_TRIGGER   = 2;
  localparam int CTL_STOP      = 4;
  localparam int CTL_WIN_EN    = 5;

  // ****************************************************************
  // Configuration fields and reset value.
  // ****************************************************************
  localparam int CFG_DECIM_LO = 6;
  localparam int CFG_ATTEN_LO = 8;
  localparam int CFG_REPEAT   = 11;
  localparam int CFG_WIDTH16  = 17;
  localparam int CFG_BYPASS   = 18;
  localparam int CFG_MICRATE  = 20;
  localparam int CFG_NOWAIT   = 21;
  localparam int CFG_MICOUT   = 22;
  localparam logic [31:0] CFG_RESET    = 32'hFFFF_FFC0; // Upper field reset values.
  localparam logic [31:0] CFG_WR_MASK  = 32'h0076_0BC0; // Writable bits.

  // ****************************************************************
  // Event bits and reset values.
  // ****************************************************************
  localparam int EV_CAL  = 0;
  localparam int EV_BUSY = 1;
  localparam int EV_EOC  = 2;
  localparam int EV_WIN  = 3;
  localparam logic [3:0]  MASK_RESET   = 4'hF;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] UPPER_RESET  = 32'h0FFF_FFFF;
  localparam logic [31:0] LOWER_RESET  = 32'h0000_0000;

  // ****************************************************************
  // Decimation ratios and attenuation codes.
  // ****************************************************************
  localparam logic [7:0] DECIM_200 = 8'hC8;
  localparam logic [7:0] DECIM_100 = 8'h64;
  localparam logic [7:0] DECIM_64  = 8'h40;
  localparam logic [7:0] DECIM_32  = 8'h20;
  localparam logic [1:0] ATTEN_0DB   = 2'h0;
  localparam logic [1:0] ATTEN_6DB   = 2'h1;
  localparam logic [1:0] ATTEN_9DB   = 2'h2;

  // ****************************************************************
  // Timing: clock, microphone clock and settle wait.
  // ****************************************************************
  localparam int SYS_CLK_KHZ    = 250000;
  localparam int MIC_SLOW_KHZ   = 800;
  localparam int MIC_FAST_KHZ   = 1600;
  // Half periods in system cycles, rounded down.
  localparam int MIC_SLOW_HALF  = SYS_CLK_KHZ / (2 * MIC_SLOW_KHZ);
  localparam int MIC_FAST_HALF  = SYS_CLK_KHZ / (2 * MIC_FAST_KHZ);
  localparam int SETTLE_NS      = 1000;
  localparam int SETTLE_CYCLES  = (SETTLE_NS * 250 + 999) / 1000;

endpackage : conv_ctrl_pkg

// *** rtl/mic_clock_gen.sv ***
// Divider that makes the microphone clock for a general-purpose pin.
`timescale 1ns/1ps
module mic_clock_gen
  import conv_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic fast,
  output logic      pin_out
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [7:0] count; // Cycles left in the current half period.
    logic       level; // Present clock level.
  } gen_state_t;

  gen_state_t s_q;   // Registered state.
  gen_state_t s_d;   // Next state.

  // Counts the half period and toggles the level; parks low when off.
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.count = 8'h00;
      s_d.level = 1'b0;
    end else if (s_q.count == 8'h00) begin
      s_d.count = fast ? 8'(MIC_FAST_HALF - 1) : 8'(MIC_SLOW_HALF - 1);
      s_d.level = ~s_q.level;
    end else begin
      s_d.count = s_q.count - 8'h01;
    end
  end

  // Registers the state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.level;

endmodule : mic_clock_gen

// *** rtl/conv_ctrl.sv ***
// Register and event control for the on-chip converter.
//
// Functional notes
// - Decimation code selects 200, 100, 64, 32.
// - Attenuator code selects 0, 6.02, 9.54 dB.
// - Bit 11 chooses single or continuous conversion.
// - Bit 17 selects 32 or 16 bit result.
// - Bit 18 bypasses the comb filter stage.
// - Rate bit picks 0.8 or 1.6 MHz.
// - Bit 21 skips the wake-up wait.
// - Bit 22 drives microphone clock on pin.
// - Calibration done sets bit 0, read clears.
// - Busy bit clears on read only when idle.
// - Conversion end sets bit 2, read clears.
// - Window hit sets bit 3, read clears.
// - Mask zero enables; masks reset to one.
// - Result read only, signed, resets zero.
// - Result mapped on 32 or 16 bits.
// - Window hit when value between limits.
// - Analog on first, trigger starts conversion.
`timescale 1ns/1ps
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int SETTLE_WAIT = SETTLE_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             IRQ,
  input  wire logic        FILT_VALID,
  input  wire logic [31:0] FILT_DATA,
  input  wire logic        CAL_DONE,
  output logic             ANALOG_ON,
  output logic             CAL_START,
  output logic             FILT_START,
  output logic             FILT_RUN,
  output logic [7:0]       DECIM_RATIO,
  output logic [1:0]       ATTEN_CODE,
  output logic             COMB_BYPASS,
  output logic             MIC_CLK_PIN,
  output logic             MIC_CLK_OE
);

  // ****************************************************************
  // State types.
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_CONVERT
  } conv_phase_t;

  typedef struct packed {
    conv_phase_t phase;      // Conversion sequencer phase.
    logic [15:0] wait_cnt;   // Settle cycles left.
    logic [5:0]  ctrl;       // Control word bits.
    logic [31:0] config_w;   // Configuration word.
    logic [3:0]  events;     // Sticky event bits.
    logic [3:0]  mask;       // Event masks.
    logic [31:0] result;     // Last converted value.
    logic [31:0] upper;      // Upper window limit.
    logic [31:0] lower;      // Lower window limit.
    logic [31:0] rdata;      // Read data for the bus.
    logic        irq;        // Interrupt output.
    logic        cal_pulse;  // Calibration start pulse.
    logic        start;      // Filter start pulse.
    logic [7:0]  ratio;      // Decimation ratio to filter.
    logic [1:0]  atten;      // Attenuation code to front end.
    logic        run;        // Convert phase flag to the filter.
  } ctl_state_t;

  ctl_state_t s_q;           // Registered state.
  ctl_state_t s_d;           // Next state.
  logic       mic_level;     // Divided microphone clock.
  logic [31:0] mapped;       // Result after width mapping.
  logic        in_window;    // New sample lies between limits.

  // ****************************************************************
  // Microphone clock divider.
  // ****************************************************************
  mic_clock_gen u_mic (
    .clk     (SYS_CLK),
    .resetn  (RESETN),
    .enable  (s_q.config_w[CFG_MICOUT]),
    .fast    (s_q.config_w[CFG_MICRATE]),
    .pin_out (mic_level)
  );

  // ****************************************************************
  // Sample mapping and window test.
  // ****************************************************************

  // In 16-bit mode the value keeps its upper half; low bits are lost.
  always_comb begin
    if (s_q.config_w[CFG_WIDTH16]) begin
      mapped = {FILT_DATA[31:16], 16'h0000};
    end else begin
      mapped = FILT_DATA;
    end
    // Signed compare, since the result is two's complement.
    in_window = ($signed(mapped) <= $signed(s_q.upper))
             && ($signed(mapped) >= $signed(s_q.lower));
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Handles the register bus, the sequencer and the events together.
  always_comb begin
    logic [3:0] set_ev;  // Events raised this cycle.
    logic [3:0] clr_ev;  // Events cleared by a read.
    logic       trig;    // Software trigger written this cycle.
    set_ev = 4'h0;
    clr_ev = 4'h0;
    trig   = 1'b0;
    s_d = s_q;
    s_d.cal_pulse = 1'b0;
    s_d.start     = 1'b0;
    s_d.rdata     = 32'h0000_0000;

    // Register writes.
    if (WR) begin
      unique case (ADDR)
        OFF_CTRL: begin
          s_d.ctrl      = WDATA[5:0];
          s_d.ctrl[CTL_TRIGGER]  = 1'b0;
          s_d.ctrl[CTL_CAL_START] = 1'b0;
          s_d.ctrl[CTL_STOP] = 1'b0;
          trig          = WDATA[CTL_TRIGGER];
          s_d.cal_pulse = WDATA[CTL_CAL_START];
          if (WDATA[CTL_STOP]) begin
            s_d.ctrl[CTL_ANALOG_ON] = 1'b0;
            s_d.phase = ST_IDLE;
          end
        end
        OFF_CONFIG: begin
          // Only writable fields change; reserved bits keep reset value.
          s_d.config_w = (WDATA & CFG_WR_MASK)
                       | (CFG_RESET & ~CFG_WR_MASK);
        end
        OFF_MASK:  s_d.mask  = WDATA[3:0];
        OFF_UPPER: s_d.upper = WDATA;
        OFF_LOWER: s_d.lower = WDATA;
        default: begin
        end
      endcase
    end

    // Register reads; data stands in the next cycle.
    if (RD) begin
      unique case (ADDR)
        OFF_CTRL:   s_d.rdata = {26'h0, s_q.ctrl};
        OFF_CONFIG: s_d.rdata = s_q.config_w;
        OFF_STATUS: begin
          s_d.rdata = {28'h0, s_q.events};
          clr_ev = 4'hF;
          // Busy survives a read while the conversion is still active.
          if (s_q.phase != ST_IDLE) begin
            clr_ev[EV_BUSY] = 1'b0;
          end
        end
        OFF_MASK:   s_d.rdata = {28'h0, s_q.mask};
        OFF_RESULT: s_d.rdata = s_q.result;
        OFF_UPPER:  s_d.rdata = s_q.upper;
        OFF_LOWER:  s_d.rdata = s_q.lower;
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Sequencer: a trigger only counts while the analog side is on.
    unique case (s_q.phase)
      ST_IDLE: begin
        if (trig && s_q.ctrl[CTL_ANALOG_ON]) begin
          if (s_q.config_w[CFG_NOWAIT]) begin
            s_d.phase = ST_CONVERT;
            s_d.start = 1'b1;
          end else begin
            s_d.phase    = ST_SETTLE;
            s_d.wait_cnt = 16'(SETTLE_WAIT - 1);
          end
        end
      end
      ST_SETTLE: begin
        if (s_q.wait_cnt == 16'h0000) begin
          s_d.phase = ST_CONVERT;
          s_d.start = 1'b1;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt - 16'h0001;
        end
      end
      ST_CONVERT: begin
        if (FILT_VALID) begin
          s_d.result = mapped;
          set_ev[EV_EOC] = 1'b1;
          if (s_q.ctrl[CTL_WIN_EN] && in_window) begin
            set_ev[EV_WIN] = 1'b1;
          end
          // Single mode stops after one sample; continuous keeps going.
          if (!s_q.config_w[CFG_REPEAT]) begin
            s_d.phase = ST_IDLE;
          end
        end
      end
      default: s_d.phase = ST_IDLE;
    endcase
    // A stop write ends conversion even mid-sequence.
    if (WR && ADDR == OFF_CTRL && WDATA[CTL_STOP]) begin
      s_d.phase = ST_IDLE;
    end

    if (s_q.phase != ST_IDLE) begin
      set_ev[EV_BUSY] = 1'b1;
    end
    if (CAL_DONE) begin
      set_ev[EV_CAL] = 1'b1;
    end

    // A new event wins over a clear in the same cycle.
    s_d.events = (s_q.events & ~clr_ev) | set_ev;

    // Decimation ratio decode.
    unique case (s_d.config_w[CFG_DECIM_LO +: 2])
      2'h0: s_d.ratio = DECIM_200;
      2'h1: s_d.ratio = DECIM_100;
      2'h2: s_d.ratio = DECIM_64;
      2'h3: s_d.ratio = DECIM_32;
    endcase
    // Code 3 has no defined attenuation; treat it as 0 dB.
    unique case (s_d.config_w[CFG_ATTEN_LO +: 2])
      2'h1:    s_d.atten = ATTEN_6DB;
      2'h2:    s_d.atten = ATTEN_9DB;
      default: s_d.atten = ATTEN_0DB;
    endcase

    // Registered copy of the phase decode, so the pin comes from a flop.
    s_d.run = (s_d.phase == ST_CONVERT);

    s_d.irq = |(s_d.events & ~s_d.mask);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // All state resets to constants.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q          <= '0;
      s_q.phase    <= ST_IDLE;
      s_q.config_w <= CFG_RESET;
      s_q.mask     <= MASK_RESET;
      s_q.result   <= RESULT_RESET;
      s_q.upper    <= UPPER_RESET;
      s_q.lower    <= LOWER_RESET;
      s_q.ratio    <= DECIM_32;
      s_q.atten    <= ATTEN_0DB;
    end else begin
      s_q <= s_d;
    end
  end

  // Separate flops keep the pin outputs registered.
  logic mic_pin_q;  // Registered pin level.
  logic mic_oe_q;   // Registered pin enable.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mic_pin_q <= 1'b0;
      mic_oe_q  <= 1'b0;
    end else begin
      mic_pin_q <= mic_level;
      mic_oe_q  <= s_q.config_w[CFG_MICOUT];
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign RDATA       = s_q.rdata;
  assign IRQ         = s_q.irq;
  assign ANALOG_ON   = s_q.ctrl[CTL_ANALOG_ON];
  assign CAL_START   = s_q.cal_pulse;
  assign FILT_START  = s_q.start;
  assign FILT_RUN    = s_q.run;
  assign DECIM_RATIO = s_q.ratio;
  assign ATTEN_CODE  = s_q.atten;
  assign COMB_BYPASS = s_q.config_w[CFG_BYPASS];
  assign MIC_CLK_PIN = mic_pin_q;
  assign MIC_CLK_OE  = mic_oe_q;

endmodule : conv_ctrl

// *** verif/filter_model.sv ***
// Behavioural converter front end and decimation filter.
`timescale 1ns/1ps
module filter_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        filt_start,
  input  wire logic        filt_run,
  input  wire logic        cal_start,
  input  wire logic [7:0]  lat,
  input  wire logic [31:0] sample,
  output logic             filt_valid,
  output logic [31:0]      filt_data,
  output logic             cal_done
);
  logic [7:0] cnt_q; // Cycles to the next sample.
  logic [7:0] cal_q; // Cycles to the end of calibration.
  // One sample every lat cycles, and only while the convert phase runs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q      <= 8'h00;
      cal_q      <= 8'h00;
      filt_valid <= 1'b0;
      filt_data  <= 32'h0;
      cal_done   <= 1'b0;
    end else begin
      filt_valid <= 1'b0;
      filt_data  <= ~filt_data; // Stale data keeps moving so it never looks valid.
      cal_done   <= cal_q == 8'h01;
      cal_q      <= cal_start ? lat : ((cal_q == 8'h00) ? 8'h00 : cal_q - 8'h01);
      if (filt_start) begin
        cnt_q <= lat;
      end else if (filt_run && cnt_q == 8'h01) begin
        filt_valid <= 1'b1;
        filt_data  <= sample;
        cnt_q      <= lat;
      end else begin
        cnt_q <= (cnt_q > 8'h01) ? cnt_q - 8'h01 : 8'h00;
      end
    end
  end
endmodule : filter_model

// *** verif/conv_ctrl_assertions.sv ***
// Port checker for the converter control block.
`timescale 1ns/1ps
module conv_ctrl_assertions
  import conv_ctrl_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ,
  input wire logic        ANALOG_ON,
  input wire logic        FILT_START,
  input wire logic        FILT_RUN,
  input wire logic [7:0]  DECIM_RATIO,
  input wire logic [1:0]  ATTEN_CODE,
  input wire logic        COMB_BYPASS,
  input wire logic        MIC_CLK_PIN,
  input wire logic        MIC_CLK_OE
);
  logic [3:0]  msk_q; // Copy of the event mask.
  logic [31:0] cfg_q; // Last configuration word written.
  logic        cw;    // Configuration write this cycle.
  assign cw = WR && ADDR == OFF_CONFIG;
  // Shadows follow bus writes, so no internal probe is needed.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      msk_q <= MASK_RESET;
      cfg_q <= CFG_RESET;
    end else if (WR && ADDR == OFF_MASK) begin
      msk_q <= WDATA[3:0];
    end else if (cw) begin
      cfg_q <= WDATA;
    end
  end
  function automatic logic [7:0] ratio(input logic [1:0] c);
    case (c)
      2'h0: ratio = DECIM_200;
      2'h1: ratio = DECIM_100;
      2'h2: ratio = DECIM_64;
      default: ratio = DECIM_32;
    endcase
  endfunction : ratio
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  // A mask write in the same cycle may unmask a pending event.
  irq_masked_a: assert property (
    msk_q == 4'hF && !(WR && ADDR == OFF_MASK) |=> !IRQ)
    else $error("interrupt with all events masked");
  mask_read_a: assert property (
    RD && ADDR == OFF_MASK |=> RDATA == {28'h0, $past(msk_q)})
    else $error("mask read back wrong");
  rd_idle_a: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero without read");
  cfg_rsvd_a: assert property (
    RD && ADDR == OFF_CONFIG |=> (RDATA & ~CFG_WR_MASK) == (CFG_RESET & ~CFG_WR_MASK))
    else $error("reserved configuration bits wrong");
  stat_rsvd_a: assert property (RD && ADDR == OFF_STATUS |=> RDATA[31:4] == 28'h0)
    else $error("reserved status bits set");
  decim_map_a: assert property (cw ##1 !cw |=> DECIM_RATIO == ratio(cfg_q[7:6]))
    else $error("decimation ratio wrong");
  atten_map_a: assert property (
    cw ##1 !cw |=> ATTEN_CODE == ((cfg_q[9:8] == 2'h3) ? 2'h0 : cfg_q[9:8]))
    else $error("attenuator code wrong");
  comb_skip_a: assert property (cw ##1 !cw |=> COMB_BYPASS == cfg_q[CFG_BYPASS])
    else $error("comb bypass wrong");
  mic_quiet_a: assert property (
    !MIC_CLK_OE && !$past(MIC_CLK_OE) && !$past(MIC_CLK_OE, 2) |-> $stable(MIC_CLK_PIN))
    else $error("mic clock moves while disabled");
  // A trigger only counts once the analog side is already on.
  start_now_a: assert property (
    cfg_q[CFG_NOWAIT] && ANALOG_ON && !FILT_RUN && WR && ADDR == OFF_CTRL
    && WDATA[2:0] == 3'h5 && !WDATA[CTL_STOP] |=> FILT_START && FILT_RUN)
    else $error("conversion did not start at once");
endmodule : conv_ctrl_assertions
bind conv_ctrl conv_ctrl_assertions u_conv_ctrl_assertions (.*);

// *** verif/tb.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb
  import conv_ctrl_pkg::*;
;
  localparam int WAIT_SIM = 4; // Short settle wait keeps the run brief.
  typedef struct {
    logic [31:0] cfg;
    logic [7:0]  dec;
    logic [1:0]  att;
    logic        byp;
    logic        oe;
  } row_t;
  // Configuration words beside the outputs they should give.
  row_t        rows[4] = '{'{32'h0, DECIM_200, ATTEN_0DB, 1'b0, 1'b0},
                          '{32'h0004_0140, DECIM_100, ATTEN_6DB, 1'b1, 1'b0},
                          '{32'h0040_0280, DECIM_64, ATTEN_9DB, 1'b0, 1'b1},
                          '{32'hFFFF_FFFF, DECIM_32, ATTEN_0DB, 1'b1, 1'b1}};
  logic        clk, rstn, wr_s, rd_s, irq, f_valid, cal_done, an_on, cal_go;
  logic        f_start, f_run, byp, pin, oe;
  logic [7:0]  addr, dec, lat;
  logic [1:0]  att;
  logic [31:0] wdata, rdata, f_data, sample;
  int          err_count, num_checks, n;
  conv_ctrl #(.SETTLE_WAIT(WAIT_SIM)) u_conv_ctrl (
    .SYS_CLK(clk), .RESETN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .IRQ(irq), .FILT_VALID(f_valid), .FILT_DATA(f_data), .CAL_DONE(cal_done),
    .ANALOG_ON(an_on), .CAL_START(cal_go), .FILT_START(f_start), .FILT_RUN(f_run),
    .DECIM_RATIO(dec), .ATTEN_CODE(att), .COMB_BYPASS(byp), .MIC_CLK_PIN(pin), .MIC_CLK_OE(oe));
  filter_model u_filter_model (
    .clk(clk), .resetn(rstn), .filt_start(f_start), .filt_run(f_run), .cal_start(cal_go),
    .lat(lat), .sample(sample), .filt_valid(f_valid), .filt_data(f_data), .cal_done(cal_done));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // Bus cycles: strobes rise after one edge and fall after the next.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e & m, "read data");
  endtask : rd
  // Bounded wait; a hang ends the run through the closing report.
  task automatic wait_on(ref logic s, input logic v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== v && n < 2000);
    if (s !== v) begin
      chk(1'b0, 1'b1, "wait timed out");
      wrap_up();
    end
  endtask : wait_on
  task automatic meas(input int h);
    repeat (3) wait_on(pin, ~pin);
    chk(n, h, "mic half period");
  endtask : meas
  task automatic chk_reset();
    @(negedge clk);
    chk(dec, DECIM_32, "decimation after reset");
    rd(OFF_CONFIG, CFG_RESET);
    rd(OFF_MASK, 32'hF);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_RESULT, RESULT_RESET);
    chk(oe, 1'b1, "mic output after reset");
  endtask : chk_reset
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {clk, rstn, wr_s, rd_s, addr, wdata, sample} = '0;
    lat = 8'd20;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    chk_reset();
    foreach (rows[i]) begin
      wr(OFF_CONFIG, rows[i].cfg);
      @(posedge clk);
      @(negedge clk);
      chk(dec, rows[i].dec, "decimation");
      chk(att, rows[i].att, "attenuator");
      chk(byp, rows[i].byp, "comb bypass");
      chk(oe, rows[i].oe, "mic enable");
      rd(OFF_CONFIG, (rows[i].cfg & CFG_WR_MASK) | (CFG_RESET & ~CFG_WR_MASK));
    end
    meas(MIC_FAST_HALF);
    wr(OFF_CONFIG, 32'h0040_0000);
    meas(MIC_SLOW_HALF);
    // Single conversion with the settle wait, end of conversion unmasked.
    sample = 32'h8000_1234;
    wr(OFF_MASK, 32'hB);
    // Analog side first: a trigger in the same write would be ignored.
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h5);
    wait_on(f_start, 1'b1);
    chk(n, WAIT_SIM + 1, "settle wait");
    chk(an_on, 1'b1, "analog on");
    rd(OFF_STATUS, 32'h2);
    rd(OFF_STATUS, 32'h2);
    wait_on(irq, 1'b1);
    chk(f_run, 1'b0, "single conversion stops");
    wr(OFF_RESULT, 32'hFFFF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(OFF_RESULT, 32'h8000_1234);
    rd(8'h10, 32'h0);
    rd(OFF_STATUS, 32'h6);
    rd(OFF_STATUS, 32'h0);
    chk(irq, 1'b0, "interrupt released");
    // Continuous 16-bit conversion with window compare, prompt filter.
    sample = 32'h0001_5678;
    lat = 8'd1;
    wr(OFF_MASK, 32'h7);
    wr(OFF_CONFIG, 32'h0022_0800);
    wr(OFF_CTRL, 32'h25);
    wait_on(irq, 1'b1);
    rd(OFF_RESULT, 32'h0001_0000);
    rd(OFF_STATUS, 32'hE);
    chk(f_run, 1'b1, "continuous keeps running");
    wr(OFF_CTRL, 32'h11);
    wait_on(f_run, 1'b0);
    rd(OFF_STATUS, 32'hE);
    rd(OFF_STATUS, 32'h0);
    // Calibration with a slow front end.
    lat = 8'd30;
    wr(OFF_MASK, 32'hE);
    wr(OFF_CTRL, 32'h3);
    wait_on(irq, 1'b1);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_STATUS, 32'h0);
    // Reset again in the middle of a continuous run.
    wr(OFF_CTRL, 32'h25);
    repeat (3) @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    chk_reset();
    wrap_up();
  end
endmodule : tb
